// ==== common/wdt_pkg.sv ====
package wdt_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  RANGE_OFF     = 8'h04;
  localparam logic [7:0]  COUNT_OFF     = 8'h08;
  localparam logic [7:0]  RESTART_OFF   = 8'h0C;
  localparam logic [7:0]  STATE_OFF     = 8'h10;
  localparam logic [7:0]  CLEAR_OFF     = 8'h14;
  localparam logic [7:0]  EVT_STAT_OFF  = 8'h18;
  localparam logic [7:0]  EVT_MASK_OFF  = 8'h1C;
  localparam logic [7:0]  PARAM5_OFF    = 8'hE4;
  localparam logic [7:0]  PARAM4_OFF    = 8'hE8;
  localparam logic [7:0]  PARAM3_OFF    = 8'hEC;
  localparam logic [7:0]  PARAM2_OFF    = 8'hF0;
  localparam logic [7:0]  PARAM1_OFF    = 8'hF4;
  localparam logic [7:0]  VERSION_OFF   = 8'hF8;
  localparam logic [7:0]  TYPE_OFF      = 8'hFC;

  // ==========================================================================
  // Values and field positions
  localparam logic [31:0] RESTART_KEY   = 32'h0000_0076;
  localparam logic [31:0] COUNT_RESET   = 32'h0000_FFFF;
  localparam logic [31:0] PARAM_ONE_VAL = 32'h1000_0242;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam int          EN_BIT        = 0;
  localparam int          MODE_BIT      = 1;
  localparam int          PW_LSB        = 2;
  localparam int          PW_W          = 3;
  localparam int          SPARE_BIT     = 5;
  localparam logic        MODE_RESET_VAL = 1'b1;
  localparam int          TOP_W         = 4;
  localparam int          RELOAD_LSB    = 0;
  localparam int          INIT_LSB      = 4;
  localparam int          EVT_W         = 2;
  localparam int          EVT_IRQ       = 0;
  localparam int          EVT_WARM      = 1;
  localparam int          BASE_EXP      = 16;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef enum logic {
    RESP_RESET,
    RESP_IRQ_FIRST
  } resp_t;

  typedef enum {
    ST_OFF,
    ST_RUN
  } run_state_t;

  // Period of 2^(base+n) cycles for a 4-bit selection
  function automatic logic [31:0] period_of(input int base, input logic [TOP_W-1:0] sel);
    period_of = 32'h0000_0001 << (base + int'(sel));
  endfunction : period_of

endpackage : wdt_pkg

// ==== rtl/wdt_downcount.sv ====
`timescale 1ns/1ps
module wdt_downcount
  import wdt_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] reload_val,
  output logic      [W-1:0] count,
  output logic              expire
);

  // ==========================================================================
  // Down-counter
  assign expire = run && (count == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= W'(COUNT_RESET);
    end else if (load) begin
      count <= load_val;
    end else if (expire) begin
      // Wraps to the period and keeps going
      count <= reload_val;
    end else if (run) begin
      count <= count - W'(1);
    end
  end

endmodule : wdt_downcount

// ==== rtl/wdt_pulse.sv ====
`timescale 1ns/1ps
module wdt_pulse
  import wdt_pkg::*;
#(
  parameter int SEL_W = PW_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [SEL_W-1:0] width_sel,
  output logic                  active
);

  localparam int CNT_W = 2 ** SEL_W;

  logic [CNT_W-1:0] remain_r;

  // ==========================================================================
  // Pulse of 2^(sel+1) cycles; a start during a pulse is absorbed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active   <= 1'b0;
      remain_r <= '0;
    end else if (!active && start) begin
      active   <= 1'b1;
      remain_r <= CNT_W'((32'h0000_0002 << width_sel) - 32'h0000_0001);
    end else if (active) begin
      if (remain_r == '0) begin
        active <= 1'b0;
      end else begin
        remain_r <= remain_r - CNT_W'(1);
      end
    end
  end

endmodule : wdt_pulse

// ==== rtl/watchdog_timer_registers.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module watchdog_timer_registers
  import wdt_pkg::*;
#(
  parameter logic             FIXED_PERIOD = 1'b0,
  parameter logic             FORCED_ON    = 1'b0,
  parameter logic [TOP_W-1:0] FIXED_INIT   = 4'h0,
  parameter logic [TOP_W-1:0] FIXED_RELOAD = 4'h0,
  parameter int               PERIOD_EXP   = BASE_EXP,
  parameter logic [31:0]      VERSION_VAL  = 32'h0000_0001,  // Arbitrary value
  parameter logic [31:0]      TYPE_VAL     = 32'h0000_0002   // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire bus_req_t    bus_req,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  output logic             warm_reset_req
);

  // ==========================================================================
  // Declarations
  logic             watchdog_on_r;
  resp_t            response_select_r;
  logic [PW_W-1:0]  pulse_sel_r;
  logic             spare_r;
  logic [TOP_W-1:0] init_sel_r;
  logic [TOP_W-1:0] reload_sel_r;
  logic             pending_r;
  logic [EVT_W-1:0] evt_stat_r;
  logic [EVT_W-1:0] evt_mask_r;
  logic [31:0]      rdata_nxt;
  logic [31:0]      count;
  logic             expire;
  logic             first_load;
  logic             kick;
  logic             clear_read;
  logic             raise_irq;
  logic             want_reset;
  logic [EVT_W-1:0] evt_set;
  logic             wr_ctrl;
  logic             wr_range;
  logic             wr_evt_stat;
  logic             wr_evt_mask;
  run_state_t       state_r;

  function automatic logic hit(input bus_req_t r, input logic [ADDR_W-1:0] off, input logic is_wr);
    hit = (is_wr ? r.wr : r.rd) && (r.addr == off);
  endfunction : hit

  assign wr_ctrl     = hit(bus_req, CTRL_OFF, 1'b1);
  assign wr_range    = hit(bus_req, RANGE_OFF, 1'b1);
  assign wr_evt_stat = hit(bus_req, EVT_STAT_OFF, 1'b1);
  assign wr_evt_mask = hit(bus_req, EVT_MASK_OFF, 1'b1);

  // ==========================================================================
  // Control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_on_r <= FORCED_ON;
    end else if (wr_ctrl && bus_req.wdata[EN_BIT]) begin
      watchdog_on_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      response_select_r <= resp_t'(MODE_RESET_VAL);
      pulse_sel_r       <= '0;
      spare_r           <= 1'b0;
    end else if (wr_ctrl) begin
      response_select_r <= resp_t'(bus_req.wdata[MODE_BIT]);
      pulse_sel_r       <= bus_req.wdata[PW_LSB +: PW_W];
      spare_r           <= bus_req.wdata[SPARE_BIT];
    end
  end

  // ==========================================================================
  // Timeout range register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_sel_r   <= FIXED_INIT;
      reload_sel_r <= FIXED_RELOAD;
    end else if (wr_range) begin
      if (!FIXED_PERIOD && !FORCED_ON) begin
        init_sel_r <= bus_req.wdata[INIT_LSB +: TOP_W];
      end
      if (!FIXED_PERIOD) begin
        reload_sel_r <= bus_req.wdata[RELOAD_LSB +: TOP_W];
      end
    end
  end

  // ==========================================================================
  // Run sequencing
  // The initial period is used once, at the enabling load
  assign first_load = watchdog_on_r && (state_r == ST_OFF);
  assign kick       = hit(bus_req, RESTART_OFF, 1'b1) && (bus_req.wdata == RESTART_KEY)
                      && (state_r == ST_RUN);
  assign clear_read = hit(bus_req, CLEAR_OFF, 1'b0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          if (watchdog_on_r) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  wdt_downcount #(
    .W          (32)
  ) u_count (
    .clk        (clk),
    .rst        (rst),
    .run        (state_r == ST_RUN),
    .load       (first_load || kick),
    .load_val   (first_load ? period_of(PERIOD_EXP, init_sel_r)
                            : period_of(PERIOD_EXP, reload_sel_r)),
    .reload_val (period_of(PERIOD_EXP, reload_sel_r)),
    .count      (count),
    .expire     (expire)
  );

  // ==========================================================================
  // Timeout response
  // A kick in the expiry cycle wins the count, but the timeout still counts
  assign raise_irq  = expire && (response_select_r == RESP_IRQ_FIRST) && !pending_r;
  assign want_reset = expire && ((response_select_r == RESP_RESET) || pending_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (raise_irq) begin
      pending_r <= 1'b1;
    end else if (kick || clear_read) begin
      pending_r <= 1'b0;
    end
  end

  wdt_pulse #(
    .SEL_W     (PW_W)
  ) u_pulse (
    .clk       (clk),
    .rst       (rst),
    .start     (want_reset),
    .width_sel (pulse_sel_r),
    .active    (warm_reset_req)
  );

  // ==========================================================================
  // Event status and mask
  assign evt_set = {want_reset, raise_irq};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_stat_r <= '0;
    end else begin
      // Set beats a write-one clear in the same cycle
      evt_stat_r <= (evt_stat_r & ~(wr_evt_stat ? bus_req.wdata[EVT_W-1:0] : '0)) | evt_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_mask_r <= '0;
    end else if (wr_evt_mask) begin
      evt_mask_r <= bus_req.wdata[EVT_W-1:0];
    end
  end

  assign irq = |(evt_stat_r & evt_mask_r);

  // ==========================================================================
  // Read path
  always_comb begin
    rdata_nxt = ZERO_WORD;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CTRL_OFF: begin
          rdata_nxt[EN_BIT]              = watchdog_on_r;
          rdata_nxt[MODE_BIT]            = response_select_r;
          rdata_nxt[PW_LSB +: PW_W]      = pulse_sel_r;
          rdata_nxt[SPARE_BIT]           = spare_r;
        end
        RANGE_OFF: begin
          rdata_nxt[INIT_LSB +: TOP_W]   = init_sel_r;
          rdata_nxt[RELOAD_LSB +: TOP_W] = reload_sel_r;
        end
        COUNT_OFF:    rdata_nxt = count;
        RESTART_OFF:  rdata_nxt = ZERO_WORD;
        STATE_OFF:    rdata_nxt[0] = !pending_r;
        CLEAR_OFF:    rdata_nxt = ZERO_WORD;
        EVT_STAT_OFF: rdata_nxt[EVT_W-1:0] = evt_stat_r;
        EVT_MASK_OFF: rdata_nxt[EVT_W-1:0] = evt_mask_r;
        PARAM1_OFF:   rdata_nxt = PARAM_ONE_VAL;
        VERSION_OFF:  rdata_nxt = VERSION_VAL;
        TYPE_OFF:     rdata_nxt = TYPE_VAL;
        default:      rdata_nxt = ZERO_WORD;
      endcase
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= ZERO_WORD;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_key_kick;
    bus_req.wr && (bus_req.addr == RESTART_OFF) && (bus_req.wdata == RESTART_KEY)
      && (state_r == ST_RUN) && !first_load;
  endsequence

  sequence seq_bad_kick;
    bus_req.wr && (bus_req.addr == RESTART_OFF) && (bus_req.wdata != RESTART_KEY)
      && (state_r == ST_RUN) && (count > 32'h0000_0001);
  endsequence

  sequence seq_expire;
    expire && !kick;
  endsequence

  a_key_reload: assert property (seq_key_kick |=> count == period_of(PERIOD_EXP, $past(reload_sel_r)))
    else $error("keyed restart did not reload the period");

  a_bad_key_ignored: assert property (seq_bad_kick |=> count == $past(count) - 32'h0000_0001)
    else $error("non-key restart value disturbed the count");

  a_kick_clears_irq: assert property (seq_key_kick and (!expire) |=> !pending_r
                                      ##1 (reg_rdata[0] || !$past(bus_req.rd && bus_req.addr == STATE_OFF)))
    else $error("restart left the interrupt pending");

  a_restart_reads: assert property (bus_req.rd && bus_req.addr == RESTART_OFF |=> reg_rdata == ZERO_WORD)
    else $error("restart register read nonzero");

  a_state_polar: assert property (bus_req.rd && bus_req.addr == STATE_OFF |=> reg_rdata[0] == !$past(pending_r))
    else $error("interrupt state bit has wrong sense");

  a_clear_on_read: assert property (clear_read && !raise_irq |=> !pending_r && reg_rdata == ZERO_WORD
                                    && count == $past(count) - 32'h0000_0001 || !$past(state_r == ST_RUN)
                                    || $past(expire || kick))
    else $error("interrupt clear read misbehaved");

  a_param_one: assert property (bus_req.rd && bus_req.addr == PARAM1_OFF |=> reg_rdata == PARAM_ONE_VAL)
    else $error("parameter one read wrong");

  a_enable_sticky: assert property (watchdog_on_r |=> watchdog_on_r [*2])
    else $error("enable dropped without reset");

  a_mode0_reset: assert property (seq_expire and (response_select_r == RESP_RESET) && !warm_reset_req
                                  |=> warm_reset_req)
    else $error("mode 0 timeout did not request reset");

  // A write-one clear right after the set is legal, so it excuses the held bit
  a_mode1_first: assert property (raise_irq |=> pending_r && !warm_reset_req
                                  ##1 (evt_stat_r[EVT_IRQ] || $past(wr_evt_stat && bus_req.wdata[EVT_IRQ])))
    else $error("first mode 1 timeout handled wrongly");

  a_wrap_reload: assert property (seq_expire |=> count == period_of(PERIOD_EXP, $past(reload_sel_r)))
    else $error("counter did not wrap to the period");

  a_first_load: assert property (first_load |=> count == period_of(PERIOD_EXP, $past(init_sel_r))
                                 ##1 (count == period_of(PERIOD_EXP, $past(init_sel_r, 2)) - 32'h0000_0001
                                 || $past(kick)))
    else $error("enable did not load the initial period");

  a_init_locked: assert property (wr_range && (FIXED_PERIOD || FORCED_ON) |=> $stable(init_sel_r))
    else $error("initial field changed while locked");

  a_reload_locked: assert property (wr_range && FIXED_PERIOD |=> $stable(reload_sel_r))
    else $error("reload field changed while fixed");

  a_irq_level: assert property (raise_irq && evt_mask_r[EVT_IRQ] && !wr_evt_mask |=> irq)
    else $error("unmasked event without interrupt");

endmodule : watchdog_timer_registers

// ==== bench/soc_reset_model.sv ====
`timescale 1ns/1ps
module soc_reset_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq,
  input  wire logic warm_reset_req,
  output int        pulse_cnt,
  output int        last_width
);
  int run_len;

  // ==========================================================================
  // Reset acceptor
  // Only a finished request is counted, so a cut-short pulse shows as a wrong width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_len    <= 0;
      pulse_cnt  <= 0;
      last_width <= 0;
    end else if (warm_reset_req) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      pulse_cnt  <= pulse_cnt + 1;
      last_width <= run_len;
      run_len    <= 0;
    end
  end
endmodule : soc_reset_model

// ==== bench/watchdog_timer_registers_tb_top.sv ====
`timescale 1ns/1ps
module watchdog_timer_registers_tb_top;
  import wdt_pkg::*;
  localparam logic [31:0] VER = 32'h0000_0A5C;  // Arbitrary value
  localparam logic [31:0] TYP = 32'h0000_0C3A;  // Arbitrary value
  typedef struct {
    logic [7:0]  a;
    logic [31:0] v;
    logic        fo;
    logic [31:0] fe;
    logic [31:0] ff;
  } note_t;

  logic        clk;
  logic        rst;
  bus_req_t    bus_req;
  logic [31:0] reg_rdata;
  logic [31:0] rdata_fix;
  logic [31:0] rdata_frc;
  logic        irq;
  logic        warm_reset_req;
  logic [31:0] seed;
  logic [31:0] bad;
  logic        pend;
  int          n_fail;
  int          checks;
  int          pulse_cnt;
  int          last_width;
  note_t       notes[$];

  // ==========================================================================
  // Instances
  // Short periods keep each timeout of the first instance within a few dozen cycles
  watchdog_timer_registers #(.PERIOD_EXP(2), .VERSION_VAL(VER), .TYPE_VAL(TYP)) watchdog_timer_registers_inst (
    .clk(clk), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata), .irq(irq), .warm_reset_req(warm_reset_req));
  watchdog_timer_registers #(.FIXED_PERIOD(1'b1), .FIXED_INIT(4'h5), .FIXED_RELOAD(4'hA), .PERIOD_EXP(2))
    watchdog_timer_registers_fixed_inst (
    .clk(clk), .rst(rst), .bus_req(bus_req), .reg_rdata(rdata_fix), .irq(), .warm_reset_req());
  // Forced on: runs from reset and keeps its initial field locked
  watchdog_timer_registers #(.FORCED_ON(1'b1), .PERIOD_EXP(2)) watchdog_timer_registers_forced_inst (
    .clk(clk), .rst(rst), .bus_req(bus_req), .reg_rdata(rdata_frc), .irq(), .warm_reset_req());
  soc_reset_model soc_reset_model_inst (
    .clk(clk), .rst(rst), .irq(irq), .warm_reset_req(warm_reset_req), .pulse_cnt(pulse_cnt),
    .last_width(last_width));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic close_out();
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Requests are never dropped here; the next call or idle replaces them
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic fo = 1'b0, input logic [31:0] fe = '0,
                    input logic [31:0] ff = '0);
    notes.push_back('{a, e, fo, fe, ff});
    op(1'b0, a, ZERO_WORD);
  endtask : rd

  task automatic idle(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic see(input string nm, input logic e, ref logic g);
    bus_req <= '0;
    @(negedge clk);
    check(nm, {31'h0, e}, {31'h0, g});
    @(posedge clk);
  endtask : see

  task automatic wait_hi(input string nm, ref logic s, input int lim);
    int k;
    bus_req <= '0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (s !== 1'b1 && k < lim);
    check(nm, 32'h1, {31'h0, s});
    @(posedge clk);
  endtask : wait_hi

  task automatic do_reset();
    bus_req <= '0;
    rst     <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  // Random writes to read-only places, the restart register and an unmapped place, then the whole map read back
  task automatic sweep();
    logic [7:0]  ad [16] = '{CTRL_OFF, RANGE_OFF, COUNT_OFF, RESTART_OFF, STATE_OFF, CLEAR_OFF, EVT_STAT_OFF,
                            EVT_MASK_OFF, PARAM5_OFF, PARAM4_OFF, PARAM3_OFF, PARAM2_OFF, PARAM1_OFF,
                            VERSION_OFF, TYPE_OFF, 8'h20};
    logic [31:0] ev [16] = '{32'h0000_0002, ZERO_WORD, COUNT_RESET, ZERO_WORD, 32'h0000_0001, ZERO_WORD,
                            ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD, PARAM_ONE_VAL,
                            VER, TYP, ZERO_WORD};
    for (int i = 2; i < 16; i++) begin
      if (i < 6 || i > 7) wr(ad[i], xs());
    end
    for (int i = 0; i < 16; i++) begin
      rd(ad[i], ev[i]);
    end
  endtask : sweep

  // ==========================================================================
  // Read monitor
  always @(negedge clk) begin
    note_t nt;
    if (pend) begin
      nt = notes.pop_front();
      check($sformatf("rdata %h", nt.a), nt.v, reg_rdata);
      if (nt.fo) check("fixed rdata", nt.fe, rdata_fix);
      if (nt.fo) check("forced rdata", nt.ff, rdata_frc);
    end
    pend = bus_req.rd;
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst     = 1'b1;
    bus_req = '0;
    seed    = 32'h0000_435B;
    pend    = 1'b0;
    n_fail  = 0;
    checks  = 0;
    do_reset();
    sweep();
    wr(EVT_MASK_OFF, 32'h0000_0003);
    wr(RANGE_OFF, 32'hFFFF_FFFF);
    rd(RANGE_OFF, 32'h0000_00FF, 1'b1, 32'h0000_005A, 32'h0000_000F);
    wr(RANGE_OFF, 32'h0000_0031);
    wr(CTRL_OFF, 32'h0000_0003);
    idle(1);
    rd(COUNT_OFF, 32'h0000_0020);
    rd(COUNT_OFF, 32'h0000_001F);
    bad = xs();
    if (bad == RESTART_KEY) bad = bad ^ 32'h0000_0001;
    wr(RESTART_OFF, bad);
    rd(COUNT_OFF, 32'h0000_001D);
    wr(RESTART_OFF, RESTART_KEY);
    rd(COUNT_OFF, 32'h0000_0008);
    rd(COUNT_OFF, 32'h0000_0007);
    wr(RANGE_OFF, 32'h0000_0032);
    rd(COUNT_OFF, 32'h0000_0005);
    idle(5);
    rd(COUNT_OFF, 32'h0000_0010);
    rd(STATE_OFF, ZERO_WORD);
    rd(EVT_STAT_OFF, 32'h0000_0001);
    rd(CLEAR_OFF, ZERO_WORD);
    rd(STATE_OFF, 32'h0000_0001);
    rd(COUNT_OFF, 32'h0000_000B);
    see("irq", 1'b1, irq);
    wr(EVT_STAT_OFF, 32'h0000_0001);
    see("irq", 1'b0, irq);
    wait_hi("irq", irq, 40);
    wr(RESTART_OFF, RESTART_KEY);
    rd(STATE_OFF, 32'h0000_0001);
    rd(RESTART_OFF, ZERO_WORD);
    wr(EVT_STAT_OFF, 32'h0000_0001);
    wait_hi("irq", irq, 40);
    see("warm", 1'b0, warm_reset_req);
    wait_hi("warm", warm_reset_req, 40);
    idle(4);
    check("pulses", 32'h1, 32'(pulse_cnt));
    check("width", 32'h2, 32'(last_width));
    rd(EVT_STAT_OFF, 32'h0000_0003);
    // Enable cannot be dropped; mode 0 with a wider pulse from here on
    wr(CTRL_OFF, 32'h0000_0030);
    rd(CTRL_OFF, 32'h0000_0031);
    wr(EVT_STAT_OFF, 32'h0000_0003);
    wait_hi("warm", warm_reset_req, 40);
    idle(34);
    check("pulses", 32'h2, 32'(pulse_cnt));
    check("width", 32'h20, 32'(last_width));
    do_reset();
    sweep();
    idle(2);
    close_out();
  end
endmodule : watchdog_timer_registers_tb_top
